// File: src/ccwd_consts.svh
// constants for the counter control word decoder
`ifndef CCWD_CONSTS_SVH
`define CCWD_CONSTS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CCWD_OFF_CTRL      8'h00
`define CCWD_OFF_STATUS    8'h04
`define CCWD_OFF_ERROR     8'h08
`define CCWD_OFF_IRQ_EN    8'h0c
`define CCWD_OFF_IRQ_POL   8'h10
`define CCWD_OFF_RESULT    8'h14
`define CCWD_OFF_STAGE     8'h20
`define CCWD_OFF_HOLD      8'h40
`define CCWD_OFF_CNT       8'h60
`define CCWD_OFF_CMP       8'h80
// ---------------------------------------------------------------
// opcodes and words
// ---------------------------------------------------------------
`define CCWD_W_MOD_RESET   16'h0100
`define CCWD_W_OUT_OFF     16'h0200
`define CCWD_W_OUT_ON      16'h0300
`define CCWD_W_IRQ_MASK    16'h0400
`define CCWD_OP_START      8'h11
`define CCWD_OP_PRELOAD    8'h12
`define CCWD_OP_HALT       8'h13
`define CCWD_OP_HALT_FETCH 8'h14
`define CCWD_OP_STEP       8'h15
`define CCWD_OP_CAPT_INT   8'h16
`define CCWD_OP_EXPOSE     8'h17
`define CCWD_OP_PRE_RUN    8'h31
`define CCWD_OP_FETCH      8'h32
`define CCWD_OP_CLEAR      8'h33
`define CCWD_OP_COMPARE    8'h34
`define CCWD_OP_DIFF       8'h35
`define CCWD_MASK_NARROW   8'h3e
`define CCWD_MASK_WIDE     8'hfe
`define CCWD_ERR_OPCODE    8'h01
`define CCWD_ERR_NONE      8'h00
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CCWD_CLK_MHZ       20
`define CCWD_RESET_US      1001
`define CCWD_RESET_CYC     (`CCWD_RESET_US * `CCWD_CLK_MHZ)
`define CCWD_WIDE_GAP_US   15
`define CCWD_WIDE_GAP_CYC  (`CCWD_WIDE_GAP_US * `CCWD_CLK_MHZ)
`endif

// File: src/ccwd_decoder.sv
// control word decoder with seven counters behind an axi4-lite slave
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "ccwd_consts.svh"
module ccwd_decoder
   import ccwd_pkg::*;
#(
   parameter int RESET_CYC = `CCWD_RESET_CYC,
   parameter int GAP_CYC   = `CCWD_WIDE_GAP_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   output logic             busy,
   output logic             outputs_enabled,
   output logic [6:0]       counter_running
);
   ccwd_state_reg_t state_reg;
   ccwd_state_reg_t state_next;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // one 32-bit register index from a word aligned byte address
   function automatic logic [5:0] ccwd_idx(input logic [7:0] a);
      return a[7:2];
   endfunction

   // byte-lane merge for partial writes
   function automatic logic [31:0] ccwd_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic       wr_fire;
   logic       accept_word;
   logic [7:0] op;
   logic [7:0] msk_n;
   logic [7:0] msk_w;
   logic [5:0] ridx;

   // handshakes are masked while ce is low, so no beat is lost to a frozen register
   assign s_awready       = ce && !state_reg.bus.awd && !state_reg.bus.bvalid;
   assign s_wready        = ce && !state_reg.bus.wd && !state_reg.bus.bvalid;
   assign s_arready       = ce && !state_reg.bus.rvalid;
   assign s_bvalid        = ce && state_reg.bus.bvalid;
   assign s_bresp         = 2'h0;
   assign s_rvalid        = ce && state_reg.bus.rvalid;
   assign s_rdata         = state_reg.bus.rdata;
   assign s_rresp         = 2'h0;
   assign busy            = (state_reg.st != ccwd_idle);
   assign outputs_enabled = state_reg.outs_on;
   assign counter_running = state_reg.running;
   assign ridx            = ccwd_idx(s_araddr);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      wr_fire = 1'b0;
      accept_word = 1'b0;
      op = 8'h00;
      msk_n = 8'h00;
      msk_w = 8'h00;
      // capture write address and data in either order
      if (s_awvalid && s_awready) begin
         state_next.bus.awd = 1'b1;
         state_next.bus.waddr = ccwd_idx(s_awaddr);
      end
      if (s_wvalid && s_wready) begin
         state_next.bus.wd = 1'b1;
         state_next.bus.wdata = ccwd_merge(32'h0, s_wdata, s_wstrb);
      end
      if (state_reg.bus.awd && state_reg.bus.wd) begin
         wr_fire = 1'b1;
         state_next.bus.awd = 1'b0;
         state_next.bus.wd = 1'b0;
         state_next.bus.bvalid = 1'b1;
      end
      if (state_reg.bus.bvalid && s_bready) begin
         state_next.bus.bvalid = 1'b0;
      end
      // register writes; a word while busy is dropped but still answered
      if (wr_fire) begin
         case (state_reg.bus.waddr)
            ccwd_idx(`CCWD_OFF_CTRL): begin
               accept_word = (state_reg.st == ccwd_idle);
            end
            ccwd_idx(`CCWD_OFF_ERROR): begin
               state_next.err = `CCWD_ERR_NONE;
            end
            ccwd_idx(`CCWD_OFF_IRQ_EN): begin
               state_next.stg_irq_en = state_reg.bus.wdata[7:0];
            end
            ccwd_idx(`CCWD_OFF_IRQ_POL): begin
               state_next.stg_irq_pol = state_reg.bus.wdata[7:0];
            end
            default: begin
               if (state_reg.bus.waddr >= ccwd_idx(`CCWD_OFF_STAGE) &&
                   state_reg.bus.waddr <  ccwd_idx(`CCWD_OFF_STAGE) + 6'h07) begin
                  state_next.stage[3'(state_reg.bus.waddr - ccwd_idx(`CCWD_OFF_STAGE))] =
                     state_reg.bus.wdata;
               end
            end
         endcase
      end
      // upper byte opcode, lower byte selection; bit 0 is the global bit
      op    = state_reg.bus.wdata[15:8];
      msk_n = state_reg.bus.wdata[7:0] & `CCWD_MASK_NARROW;
      msk_w = state_reg.bus.wdata[7:0] & `CCWD_MASK_WIDE;
      if (accept_word) begin
         state_next.sel = msk_w;
         case (op)
            8'h01: begin
               state_next.st = ccwd_reset_wait;
               state_next.wait_cnt = 32'(RESET_CYC);
            end
            8'h02: state_next.outs_on = 1'b0;
            8'h03: state_next.outs_on = 1'b1;
            8'h04: begin
               state_next.irq_en  = state_reg.stg_irq_en;
               state_next.irq_pol = state_reg.stg_irq_pol;
            end
            default: begin
               if (op != `CCWD_OP_START && op != `CCWD_OP_PRELOAD &&
                   op != `CCWD_OP_HALT && op != `CCWD_OP_HALT_FETCH &&
                   op != `CCWD_OP_STEP && op != `CCWD_OP_CAPT_INT &&
                   op != `CCWD_OP_EXPOSE && op != `CCWD_OP_PRE_RUN &&
                   op != `CCWD_OP_FETCH && op != `CCWD_OP_CLEAR &&
                   op != `CCWD_OP_COMPARE && op != `CCWD_OP_DIFF) begin
                  state_next.err = `CCWD_ERR_OPCODE;
               end
            end
         endcase
         // per-counter actions; bit k+1 selects counter k
         for (int k = 0; k < 7; k++) begin
            if (msk_n[k+1]) begin
               case (op)
                  `CCWD_OP_START:   state_next.running[k] = 1'b1;
                  `CCWD_OP_PRELOAD: state_next.cnt[k] = state_reg.stage[k];
                  `CCWD_OP_HALT:    state_next.running[k] = 1'b0;
                  `CCWD_OP_HALT_FETCH: begin
                     state_next.running[k] = 1'b0;
                     state_next.hold[k] = state_reg.cnt[k];
                  end
                  `CCWD_OP_STEP:    state_next.cnt[k] = state_reg.cnt[k] + 32'h1;
                  `CCWD_OP_CAPT_INT: state_next.ihold[k] = state_reg.cnt[k];
                  // valid only after a capture, which the host ensures
                  `CCWD_OP_EXPOSE:  state_next.hold[k] = state_reg.ihold[k];
                  default: begin
                  end
               endcase
            end
            // narrow counters act now; wide ones may be deferred
            if (msk_w[k+1] && (k < 5 || op != `CCWD_OP_FETCH)) begin
               case (op)
                  `CCWD_OP_PRE_RUN: begin
                     state_next.cnt[k] = state_reg.stage[k];
                     state_next.running[k] = 1'b1;
                  end
                  `CCWD_OP_FETCH:   state_next.hold[k] = state_reg.cnt[k];
                  `CCWD_OP_CLEAR:   state_next.cnt[k] = 32'h0;
                  `CCWD_OP_COMPARE: state_next.cmp[k] = state_reg.stage[k];
                  default: begin
                  end
               endcase
            end
         end
         // difference of the lowest two selected counters
         if (op == `CCWD_OP_DIFF) begin
            state_next.result = 32'h0;
            for (int k = 6; k >= 0; k--) begin
               for (int j = 6; j > k; j--) begin
                  if (msk_w[k+1] && msk_w[j+1]) begin
                     state_next.result = state_reg.cnt[k] - state_reg.cnt[j];
                  end
               end
            end
         end
         // counter six fetched now, seven after the service gap
         if (op == `CCWD_OP_FETCH && (msk_w[6] || msk_w[7])) begin
            if (msk_w[6]) begin
               state_next.hold[5] = state_reg.cnt[5];
            end
            if (msk_w[7]) begin
               state_next.st = ccwd_wide_wait;
               state_next.wait_cnt = 32'(GAP_CYC);
            end
         end
      end
      // free running counters tick each enabled cycle; a halted one keeps its held value
      for (int k = 0; k < 7; k++) begin
         if (state_reg.running[k] && state_next.running[k] &&
             !(accept_word && state_next.cnt[k] != state_reg.cnt[k])) begin
            state_next.cnt[k] = state_reg.cnt[k] + 32'h1;
         end
      end
      // busy phases
      case (state_reg.st)
         ccwd_idle: begin
         end
         ccwd_reset_wait: begin
            if (state_reg.wait_cnt <= 32'h1) begin
               // module reset ends in the post-parameterization state
               state_next.st = ccwd_idle;
               state_next.running = 7'h60;
               state_next.outs_on = 1'b0;
               state_next.cnt = '0;
               state_next.hold = '0;
               state_next.ihold = '0;
               state_next.cmp = '0;
               state_next.irq_en = 8'h00;
               state_next.irq_pol = 8'h00;
               state_next.err = `CCWD_ERR_NONE;
            end else begin
               state_next.wait_cnt = state_reg.wait_cnt - 32'h1;
            end
         end
         ccwd_wide_wait: begin
            if (state_reg.wait_cnt <= 32'h1) begin
               state_next.hold[6] = state_reg.cnt[6];
               state_next.st = ccwd_idle;
            end else begin
               state_next.wait_cnt = state_reg.wait_cnt - 32'h1;
            end
         end
         default: state_next.st = ccwd_idle;
      endcase
      // read channel
      if (s_arvalid && s_arready) begin
         state_next.bus.rvalid = 1'b1;
         state_next.bus.rdata = 32'h0;
         case (ridx)
            ccwd_idx(`CCWD_OFF_STATUS): begin
               state_next.bus.rdata = {23'h0, state_reg.outs_on, state_reg.st != ccwd_idle,
                                       state_reg.running};
            end
            ccwd_idx(`CCWD_OFF_ERROR):   state_next.bus.rdata = {24'h0, state_reg.err};
            ccwd_idx(`CCWD_OFF_IRQ_EN):  state_next.bus.rdata = {24'h0, state_reg.irq_en};
            ccwd_idx(`CCWD_OFF_IRQ_POL): state_next.bus.rdata = {24'h0, state_reg.irq_pol};
            ccwd_idx(`CCWD_OFF_RESULT):  state_next.bus.rdata = state_reg.result;
            default: begin
               if (ridx >= ccwd_idx(`CCWD_OFF_STAGE) &&
                   ridx < ccwd_idx(`CCWD_OFF_STAGE) + 6'h07) begin
                  state_next.bus.rdata = state_reg.stage[3'(ridx - ccwd_idx(`CCWD_OFF_STAGE))];
               end else if (ridx >= ccwd_idx(`CCWD_OFF_HOLD) &&
                            ridx < ccwd_idx(`CCWD_OFF_HOLD) + 6'h07) begin
                  state_next.bus.rdata = state_reg.hold[3'(ridx - ccwd_idx(`CCWD_OFF_HOLD))];
               end else if (ridx >= ccwd_idx(`CCWD_OFF_CNT) &&
                            ridx < ccwd_idx(`CCWD_OFF_CNT) + 6'h07) begin
                  state_next.bus.rdata = state_reg.cnt[3'(ridx - ccwd_idx(`CCWD_OFF_CNT))];
               end else if (ridx >= ccwd_idx(`CCWD_OFF_CMP) &&
                            ridx < ccwd_idx(`CCWD_OFF_CMP) + 6'h07) begin
                  state_next.bus.rdata = state_reg.cmp[3'(ridx - ccwd_idx(`CCWD_OFF_CMP))];
               end
            end
         endcase
      end
      if (state_reg.bus.rvalid && s_rready) begin
         state_next.bus.rvalid = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state register; after reset wide counters run, outputs off
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         state_reg.running <= 7'h60;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end
endmodule // ccwd_decoder

// File: src/ccwd_pkg.sv
// types for the counter control word decoder
package ccwd_pkg;
   typedef enum logic [1:0] {ccwd_idle, ccwd_reset_wait, ccwd_wide_wait} ccwd_state_t;
   typedef struct packed {
      logic        awd;
      logic        wd;
      logic [5:0]  waddr;
      logic [31:0] wdata;
      logic        bvalid;
      logic        rvalid;
      logic [31:0] rdata;
   } ccwd_bus_t;
   typedef struct packed {
      ccwd_state_t       st;
      logic [31:0]       wait_cnt;
      logic [7:0]        sel;
      logic [7:0]        err;
      logic              outs_on;
      logic [6:0]        running;
      logic [7:0]        irq_en;
      logic [7:0]        irq_pol;
      logic [7:0]        stg_irq_en;
      logic [7:0]        stg_irq_pol;
      logic [6:0][31:0]  stage;
      logic [6:0][31:0]  hold;
      logic [6:0][31:0]  ihold;
      logic [6:0][31:0]  cnt;
      logic [6:0][31:0]  cmp;
      logic [31:0]       result;
      ccwd_bus_t         bus;
   } ccwd_state_reg_t;
endpackage

// File: verification/ccwd_decoder_checker.sv
// port-level assertions for the control word decoder
`timescale 1ns/1ps
module ccwd_decoder_checker
   import ccwd_pkg::*;
#(
   parameter int RESET_CYC = 20020
)(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic [7:0]  s_awaddr,
   input wire logic        s_awvalid,
   input wire logic        s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic        s_wvalid,
   input wire logic        s_wready,
   input wire logic        s_bvalid,
   input wire logic        busy,
   input wire logic        outputs_enabled,
   input wire logic [6:0]  counter_running
);
   logic [7:0]  adr_reg;
   logic [15:0] word_reg;
   logic        bv_reg;
   logic        rst_reg;
   logic [31:0] cnt_reg;
   logic        busy_q;
   logic        outs_q;
   logic        ce_q;
   logic [6:0]  run_q;
   // a word executes on the edge that raises bvalid, one cycle before go is seen
   wire         go = s_bvalid && !bv_reg;
   // halves of a write are taken apart, so each is latched on its own handshake
   always_ff @(posedge aclk) begin
      if (s_awvalid && s_awready)
         adr_reg <= s_awaddr;
      if (s_wvalid && s_wready)
         word_reg <= s_wdata[15:0];
      bv_reg  <= aresetn && s_bvalid;
      // levels from before the executing edge, to judge what a word changed
      busy_q  <= busy;
      outs_q  <= outputs_enabled;
      ce_q    <= ce;
      run_q   <= counter_running;
      rst_reg <= aresetn && ((go && ce_q && !busy_q && adr_reg == 8'h00
                 && word_reg == 16'h0100) || (rst_reg && busy));
      cnt_reg <= (aresetn && busy) ? cnt_reg + 32'h1 : 32'h0;
   end
   // ----------------------------------------
   // control word acceptance
   // ----------------------------------------
   sequence word_s(logic [15:0] w);
      go && ce_q && !busy_q && adr_reg == 8'h00 && word_reg == w;
   endsequence
   sequence op_s(logic [7:0] op);
      go && ce_q && !busy_q && adr_reg == 8'h00 && word_reg[15:8] == op;
   endsequence
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reset_state_a: assert property ($rose(aresetn) |-> counter_running == 7'h60
      && !outputs_enabled && !busy) else $error("state after reset wrong");
   outs_off_a: assert property (word_s(16'h0200) |-> !outputs_enabled)
      else $error("outputs not disabled");
   outs_on_a: assert property (word_s(16'h0300) |-> outputs_enabled)
      else $error("outputs not enabled");
   start_narrow_a: assert property (op_s(8'h11) |-> counter_running ==
      (run_q | {2'b00, word_reg[5:1]})) else $error("start mask wrong");
   halt_narrow_a: assert property ((op_s(8'h13) or op_s(8'h14)) |->
      counter_running == (run_q & ~{2'b00, word_reg[5:1]}))
      else $error("halt mask wrong");
   start_wide_a: assert property (op_s(8'h31) |-> counter_running ==
      (run_q | word_reg[7:1])) else $error("load and run mask wrong");
   busy_start_a: assert property (word_s(16'h0100) |-> busy [*8])
      else $error("busy missing during module reset");
   busy_len_a: assert property (cnt_reg <= RESET_CYC + 2)
      else $error("busy lasts too long");
   reset_end_a: assert property ($fell(busy) && rst_reg |->
      counter_running == 7'h60 && !outputs_enabled) else $error("module reset end state wrong");
   busy_drop_a: assert property (go && busy_q && adr_reg == 8'h00 |->
      outputs_enabled == outs_q) else $error("word taken while busy");
   ce_gate_a: assert property (!ce |-> !s_awready && !s_wready && !s_bvalid)
      else $error("handshake offered while frozen");
endmodule // ccwd_decoder_checker

// File: verification/ccwd_host_model.sv
// axi4-lite master standing in for the host controller
`timescale 1ns/1ps
module ccwd_host_model (
   input  wire logic        aclk,
   output logic [7:0]       s_awaddr,
   output logic             s_awvalid,
   input  wire logic        s_awready,
   output logic [31:0]      s_wdata,
   output logic [3:0]       s_wstrb,
   output logic             s_wvalid,
   input  wire logic        s_wready,
   input  wire logic        s_bvalid,
   output logic             s_bready,
   output logic [7:0]       s_araddr,
   output logic             s_arvalid,
   input  wire logic        s_arready,
   input  wire logic [31:0] s_rdata,
   input  wire logic        s_rvalid,
   output logic             s_rready
);
   // idle bus at time zero
   initial begin
      {s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready} = '0;
      {s_araddr, s_arvalid} = '0;
      // rready stays high so back-to-back reads never toggle it in one step
      s_rready = 1'b1;
      s_wstrb = 4'hf;
   end
   // released payload is inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      {s_awaddr, s_wdata, s_awvalid, s_wvalid} <= {a, d, 2'b11};
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_awvalid && s_awready) begin
            ad = 1'b1;
            {s_awvalid, s_awaddr} <= {1'b0, ~a};
         end
         if (s_wvalid && s_wready) begin
            wd = 1'b1;
            {s_wvalid, s_wdata} <= {1'b0, ~d};
         end
      end
      // a slow host lets the response wait a little
      repeat ($urandom_range(0, 2)) @(posedge aclk);
      s_bready <= 1'b1;
      do @(posedge aclk); while (!s_bvalid);
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      {s_araddr, s_arvalid} <= {a, 1'b1};
      do @(posedge aclk); while (!s_arready);
      {s_araddr, s_arvalid} <= {~a, 1'b0};
      do @(posedge aclk); while (!s_rvalid);
      d = s_rdata;
   endtask
endmodule // ccwd_host_model

// File: verification/tb_top.sv
// self-checking bench for the control word decoder
`timescale 1ns/1ps
module tb_top;
   import ccwd_pkg::*;
   localparam int RST_N = 20;
   localparam int GAP_N = 5;
   logic        aclk, aresetn, ce, s_awvalid, s_awready, s_wvalid, s_wready;
   logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic        busy, outputs_enabled;
   logic [1:0]  s_bresp, s_rresp;
   logic [3:0]  s_wstrb;
   logic [6:0]  counter_running, run;
   logic [7:0]  s_awaddr, s_araddr, m, op;
   logic [31:0] s_wdata, s_rdata, v, a, b;
   int          failures, n_tests, i;
   ccwd_decoder #(.RESET_CYC(RST_N), .GAP_CYC(GAP_N)) dut_u (.aclk, .aresetn, .ce,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
      .s_rresp, .s_rvalid, .s_rready, .busy, .outputs_enabled, .counter_running);
   ccwd_host_model host_u (.aclk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rvalid, .s_rready);
   initial aclk = 1'b0;
   always #25 aclk = ~aclk;
   // running set expected after one counter command
   function automatic logic [6:0] f_run(input logic [6:0] r, input logic [7:0] o,
                                        input logic [7:0] s);
      case (o)
         8'h11: return r | (s[7:1] & 7'h1f);
         8'h13, 8'h14: return r & ~(s[7:1] & 7'h1f);
         8'h31: return r | s[7:1];
         default: return r;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // levels are looked at mid-cycle, once the command edge has landed
   task automatic pins(input logic [31:0] exp);
      @(negedge aclk);
      chk({23'h0, busy, outputs_enabled, counter_running}, exp);
      @(posedge aclk);
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
      host_u.rd(ad, v);
      chk(v, exp);
   endtask
   task automatic cmd(input logic [7:0] o, input logic [7:0] s);
      host_u.wr(8'h00, {16'h0000, o, s});
   endtask
   task automatic idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 200) begin
         @(posedge aclk);
         k++;
      end
      // a busy phase that never ends is a mismatch, not a silent pass
      if (k >= 200)
         failures++;
   endtask
   task automatic done(input string s);
      $display("test %0s done", s);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {aresetn, ce, failures, n_tests} = {2'b01, 64'h0};
      v = $urandom(32'h01391992);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      pins(32'h060);
      cmd(8'h03, 8'h00);
      pins(32'h0e0);
      rdc(8'h04, 32'h160);
      cmd(8'h02, 8'h00);
      pins(32'h060);
      done("outputs");
      // all-ones masks first: bits outside the narrow range must be ignored
      run = 7'h60;
      for (i = 0; i < 8; i++) begin
         m = (i < 2) ? 8'hff : 8'($urandom);
         op = i[0] ? 8'h13 : 8'h11;
         run = f_run(run, op, m);
         cmd(op, m);
         pins({25'h0, run});
      end
      cmd(8'h13, 8'h3e);
      done("start_halt");
      a = $urandom;
      b = $urandom;
      host_u.wr(8'h20, a);
      host_u.wr(8'h28, b);
      cmd(8'h12, 8'h0a);
      rdc(8'h60, a);
      rdc(8'h68, b);
      cmd(8'h35, 8'h0a);
      rdc(8'h14, a - b);
      cmd(8'h15, 8'h02);
      rdc(8'h60, a + 32'h1);
      cmd(8'h16, 8'h02);
      cmd(8'h15, 8'h02);
      cmd(8'h17, 8'h02);
      rdc(8'h40, a + 32'h1);
      cmd(8'h32, 8'h08);
      rdc(8'h48, b);
      cmd(8'h33, 8'h02);
      rdc(8'h60, 32'h0);
      cmd(8'h11, 8'h04);
      cmd(8'h14, 8'h04);
      pins(32'h060);
      host_u.rd(8'h64, a);
      rdc(8'h44, a);
      host_u.wr(8'h30, $urandom);
      cmd(8'h31, 8'h20);
      pins(32'h070);
      cmd(8'h13, 8'h20);
      a = $urandom;
      host_u.wr(8'h20, a);
      cmd(8'h34, 8'h02);
      rdc(8'h80, a);
      cmd(8'h32, 8'hc0);
      idle();
      host_u.rd(8'h54, a);
      rdc(8'h58, a + GAP_N);
      // counter seven must lose exactly the cycles in which ce is low
      host_u.rd(8'h78, a);
      ce <= 1'b0;
      repeat (10) @(posedge aclk);
      ce <= 1'b1;
      rdc(8'h78, a + 32'h2);
      done("counters");
      m = 8'($urandom);
      host_u.wr(8'h0c, {24'h0, m});
      host_u.wr(8'h10, {24'h0, ~m});
      rdc(8'h0c, 32'h0);
      cmd(8'h04, 8'h00);
      rdc(8'h0c, {24'h0, m});
      rdc(8'h10, {24'h0, ~m});
      cmd(8'h55, 8'h00);
      rdc(8'h08, 32'h1);
      host_u.wr(8'h08, 32'h0);
      rdc(8'h08, 32'h0);
      rdc(8'hfc, 32'h0);
      done("irq_error");
      cmd(8'h03, 8'h00);
      cmd(8'h01, 8'h00);
      @(negedge aclk);
      chk({31'h0, busy}, 32'h1);
      @(posedge aclk);
      cmd(8'h03, 8'h00);
      idle();
      pins(32'h060);
      rdc(8'h60, 32'h0);
      done("module_reset");
      report_and_stop();
   end
   // the sequence needs a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      report_and_stop();
   end
endmodule // tb_top
bind ccwd_decoder ccwd_decoder_checker #(.RESET_CYC(RESET_CYC)) chk_u (.aclk, .aresetn,
   .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wvalid, .s_wready, .s_bvalid,
   .busy, .outputs_enabled, .counter_running);
